// >>> src/psh_host_ctrl.sv
// host-facing reset, interrupt, serial bus, shutdown and strap logic
`timescale 1ns/1ps
`default_nettype none
`include "psh_host_ctrl_params.svh"
module psh_host_ctrl (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic resetPin_n,
  input wire logic masked_shutdown_in,
  input wire logic serialClk,
  input wire logic serial_data_sense,
  input wire logic linkClk,
  input wire logic [3:0] chanFaultTimer,
  input wire logic [3:0] chanOutBelow,
  input wire logic [3:0] chanClassOk,
  input wire logic [3:0] addrStrap,
  input wire logic [1:0] cfgStrap,
  input wire logic [1:0] link_node_strap,
  input wire logic [1:0] power_mode_strap,
  input wire logic customPkgPresent,
  input wire logic customCfg0,
  input wire logic [1:0] customPowerMode,
  input wire logic [7:0] regAddr,
  input wire logic [7:0] regWrData,
  input wire logic regWr,
  input wire logic regRd,
  output logic [7:0] regRdData,
  output logic intOut,
  output logic intOe_n,
  output logic serial_data_drive,
  output logic serialDataOe_n,
  output logic [3:0] chanSwitchOn,
  output logic [1:0] maxPowerAlloc,
  output logic [1:0] cfgSelect,
  output logic [1:0] linkNodeAddr,
  output logic deviceActive
);
  localparam int RST_FILT = `PSH_RST_FILT_CYC;
  localparam int SHDN_FILT = `PSH_SHDN_FILT_CYC;

  psh_pkg::psh_pins_t pinsRaw;
  psh_pkg::psh_pins_t sync1_reg;
  psh_pkg::psh_pins_t sync2_reg;
  psh_pkg::psh_strap_t strap_reg;
  psh_pkg::psh_i2c_state_t i2cState_reg;
  logic chipRst_reg;
  logic [7:0] rstLowCnt_reg;
  logic strapTake;
  logic [8:0] shutCnt_reg;
  logic shutActive_reg;
  logic sclPrev_reg;
  logic sdaPrev_reg;
  logic linkPrev_reg;
  logic startSeen;
  logic stopSeen;
  logic sclRise;
  logic sclFall;
  logic linkEdge;
  logic busBusy_reg;
  logic [3:0] bitCnt_reg;
  logic [7:0] shift_reg;
  logic [6:0] baseAddr;
  logic [3:0] faultCap_reg;
  logic [3:0] belowCap_reg;
  logic [3:0] classOk_reg;
  logic [7:0] evtSet;
  logic [7:0] evtClr;
  logic [7:0] evt_reg;
  logic [7:0] evt_next;
  logic [7:0] intMask_reg;
  logic [7:0] mode_reg;
  logic [3:0] shutMask_reg;
  logic [11:0] prio_reg;
  logic [3:0] powerReq_reg;
  logic [3:0] kill;
  logic [3:0] grant;
  logic intPending;
  logic wrEn;

  assign pinsRaw = '{rstPin: resetPin_n, shutdown: masked_shutdown_in, scl: serialClk,
                     sda: serial_data_sense, linkClk: linkClk, faultTimer: chanFaultTimer,
                     outBelow: chanOutBelow, classOk: chanClassOk,
                     strap: '{addrBits: addrStrap, cfgSel: cfgStrap,
                              linkNode: link_node_strap, powerMode: power_mode_strap}};

  // every pin except the custom package inputs crosses two flops; the first stage feeds only the second
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      sync1_reg <= '0;
      sync2_reg <= '0;
    end
    else
    begin
      sync1_reg <= pinsRaw;
      sync2_reg <= sync1_reg;
    end
  end

  // reset pin filter: only a low lasting the full window resets the core
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      rstLowCnt_reg <= 8'h00;
      chipRst_reg <= 1'b1;
    end
    else if (sync2_reg.rstPin)
    begin
      rstLowCnt_reg <= 8'h00;
      chipRst_reg <= 1'b0;
    end
    // one sample beyond the window, so a pulse just under it never qualifies
    else if (rstLowCnt_reg == 8'(RST_FILT))
      chipRst_reg <= 1'b1;
    else
      rstLowCnt_reg <= rstLowCnt_reg + 8'h01;
  end

  // straps are taken in the last cycle of reset, once per release
  assign strapTake = chipRst_reg && sync2_reg.rstPin;

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      strap_reg <= `PSH_STRAP_RST;
    else if (strapTake)
      strap_reg <= sync2_reg.strap;
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      cfgSelect <= 2'h0;
      maxPowerAlloc <= `PSH_PWR_DEFAULT;
      linkNodeAddr <= 2'h0;
    end
    else
    begin
      cfgSelect <= {strap_reg.cfgSel[1], customPkgPresent ? customCfg0 : strap_reg.cfgSel[0]};
      linkNodeAddr <= strap_reg.linkNode;
      if (customPkgPresent)
        maxPowerAlloc <= customPowerMode;
      else if (strap_reg.linkNode == 2'h0)
        maxPowerAlloc <= strap_reg.powerMode;
      else
        maxPowerAlloc <= `PSH_PWR_DEFAULT;
    end
  end

  // shutdown qualifier: half the minimum pulse, so a legal pulse always counts
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      shutCnt_reg <= 9'h000;
      shutActive_reg <= 1'b0;
    end
    else if (chipRst_reg || !sync2_reg.shutdown)
    begin
      shutCnt_reg <= 9'h000;
      shutActive_reg <= 1'b0;
    end
    else if (shutCnt_reg == 9'(SHDN_FILT - 1))
      shutActive_reg <= 1'b1;
    else
      shutCnt_reg <= shutCnt_reg + 9'h001;
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      sclPrev_reg <= 1'b1;
      sdaPrev_reg <= 1'b1;
      linkPrev_reg <= 1'b0;
    end
    else
    begin
      sclPrev_reg <= sync2_reg.scl;
      sdaPrev_reg <= sync2_reg.sda;
      linkPrev_reg <= sync2_reg.linkClk;
    end
  end

  assign sclRise = sync2_reg.scl && !sclPrev_reg;
  assign sclFall = !sync2_reg.scl && sclPrev_reg;
  assign startSeen = sync2_reg.scl && sclPrev_reg && sdaPrev_reg && !sync2_reg.sda;
  assign stopSeen = sync2_reg.scl && sclPrev_reg && !sdaPrev_reg && sync2_reg.sda;
  assign linkEdge = sync2_reg.linkClk && !linkPrev_reg;
  assign baseAddr = {`PSH_ADDR_FIXED_HI, strap_reg.addrBits, `PSH_ADDR_FIXED_LO};

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      busBusy_reg <= 1'b0;
    else if (chipRst_reg || stopSeen)
      busBusy_reg <= 1'b0;
    else if (startSeen)
      busBusy_reg <= 1'b1;
  end

  // address phase only: this block answers with the acknowledge of its own address
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      i2cState_reg <= psh_pkg::PSH_I2C_IDLE;
      bitCnt_reg <= 4'h0;
      shift_reg <= 8'h00;
      serialDataOe_n <= 1'b1;
    end
    else if (chipRst_reg || stopSeen)
    begin
      i2cState_reg <= psh_pkg::PSH_I2C_IDLE;
      serialDataOe_n <= 1'b1;
    end
    else if (startSeen)
    begin
      i2cState_reg <= psh_pkg::PSH_I2C_ADDR;
      bitCnt_reg <= 4'h0;
      serialDataOe_n <= 1'b1;
    end
    else
    begin
      case (i2cState_reg)
        psh_pkg::PSH_I2C_IDLE:
          serialDataOe_n <= 1'b1;
        psh_pkg::PSH_I2C_ADDR:
        begin
          if (sclRise && bitCnt_reg != 4'h8)
          begin
            shift_reg <= {shift_reg[6:0], sync2_reg.sda};
            bitCnt_reg <= bitCnt_reg + 4'h1;
          end
          else if (sclFall && bitCnt_reg == 4'h8)
          begin
            if (shift_reg[7:1] == baseAddr)
            begin
              i2cState_reg <= psh_pkg::PSH_I2C_ACK;
              serialDataOe_n <= 1'b0;
            end
            else
              i2cState_reg <= psh_pkg::PSH_I2C_DATA;
          end
        end
        psh_pkg::PSH_I2C_ACK:
          if (sclFall)
          begin
            i2cState_reg <= psh_pkg::PSH_I2C_DATA;
            serialDataOe_n <= 1'b1;
          end
        psh_pkg::PSH_I2C_DATA:
          serialDataOe_n <= 1'b1;
        default:
        begin
          i2cState_reg <= psh_pkg::PSH_I2C_IDLE;
          serialDataOe_n <= 1'b1;
        end
      endcase
    end
  end

  // channel status from the port side is taken on the sampled link clock edge
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      faultCap_reg <= 4'h0;
      belowCap_reg <= 4'h0;
      classOk_reg <= 4'h0;
    end
    else if (chipRst_reg)
    begin
      faultCap_reg <= 4'h0;
      belowCap_reg <= 4'h0;
      classOk_reg <= 4'h0;
    end
    else if (linkEdge)
    begin
      faultCap_reg <= sync2_reg.faultTimer;
      belowCap_reg <= sync2_reg.outBelow;
      classOk_reg <= sync2_reg.classOk;
    end
  end

  assign evtSet[3:0] = linkEdge ? (sync2_reg.faultTimer & ~faultCap_reg & chanSwitchOn) : 4'h0;
  assign evtSet[7:4] = linkEdge ? (sync2_reg.outBelow & ~belowCap_reg) : 4'h0;
  assign wrEn = regWr && !chipRst_reg;
  always_comb
  begin
    evtClr = 8'h00;
    if (wrEn && regAddr == `PSH_REG_RESET &&
        (regWrData[`PSH_RST_REL_LO] || regWrData[`PSH_RST_REL_HI]))
      evtClr = 8'hFF;
    else if (wrEn && regAddr == `PSH_REG_EVENT)
      evtClr = regWrData;
  end
  // a new event in the clearing cycle survives
  assign evt_next = (evt_reg & ~evtClr) | evtSet;

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      evt_reg <= 8'h00;
    else if (chipRst_reg)
      evt_reg <= 8'h00;
    else
      evt_reg <= evt_next;
  end

  assign intPending = |(evt_next & intMask_reg);

  // pin only moves while the bus is idle, so a mid-transaction fault waits for stop
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      intOe_n <= 1'b1;
    else if (chipRst_reg)
      intOe_n <= 1'b1;
    else if (!busBusy_reg && !startSeen)
      intOe_n <= !intPending;
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      intMask_reg <= `PSH_INT_MASK_RST;
      mode_reg <= `PSH_MODE_RST;
      shutMask_reg <= 4'h0;
      prio_reg <= 12'h000;
      powerReq_reg <= 4'h0;
    end
    else if (chipRst_reg)
    begin
      intMask_reg <= `PSH_INT_MASK_RST;
      mode_reg <= `PSH_MODE_RST;
      shutMask_reg <= 4'h0;
      prio_reg <= 12'h000;
      powerReq_reg <= 4'h0;
    end
    else if (wrEn)
    begin
      case (regAddr)
        `PSH_REG_INT_MASK: intMask_reg <= regWrData;
        `PSH_REG_MODE: mode_reg <= regWrData;
        `PSH_REG_SHUT_MASK: shutMask_reg <= regWrData[3:0];
        `PSH_REG_PRIO_A: prio_reg[5:0] <= regWrData[5:0];
        `PSH_REG_PRIO_B: prio_reg[11:6] <= regWrData[5:0];
        `PSH_REG_POWER_REQ: powerReq_reg <= regWrData[3:0];
        default: ;
      endcase
    end
  end

  // 1-bit scheme: masked channels drop; 3-bit scheme: channels below threshold drop
  always_comb
  begin
    kill = 4'h0;
    grant = 4'h0;
    for (int i = 0; i < 4; i++)
    begin
      if (mode_reg[`PSH_MODE_PRIO3])
        kill[i] = shutActive_reg &&
                  (prio_reg[3*i +: 3] < mode_reg[`PSH_MODE_THR_LSB +: 3]);
      else
        kill[i] = shutActive_reg && shutMask_reg[i];
      if (mode_reg[`PSH_MODE_AUTO])
        grant[i] = classOk_reg[i];
      else
        grant[i] = powerReq_reg[i];
    end
  end

  // a faulted channel stays off until its event is cleared
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      chanSwitchOn <= 4'h0;
    else if (chipRst_reg)
      chanSwitchOn <= 4'h0;
    else
      chanSwitchOn <= grant & ~kill & ~evt_next[3:0] & ~evtSet[3:0];
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      regRdData <= 8'h00;
    else if (regRd && !chipRst_reg)
    begin
      case (regAddr)
        `PSH_REG_INT_MASK: regRdData <= intMask_reg;
        `PSH_REG_EVENT: regRdData <= evt_reg;
        `PSH_REG_MODE: regRdData <= mode_reg;
        `PSH_REG_SHUT_MASK: regRdData <= {4'h0, shutMask_reg};
        `PSH_REG_PRIO_A: regRdData <= {2'h0, prio_reg[5:0]};
        `PSH_REG_PRIO_B: regRdData <= {2'h0, prio_reg[11:6]};
        `PSH_REG_POWER_REQ: regRdData <= {4'h0, powerReq_reg};
        `PSH_REG_CHAN_STAT: regRdData <= {classOk_reg, chanSwitchOn};
        `PSH_REG_ADDR_STAT: regRdData <= {1'b0, baseAddr};
        `PSH_REG_CFG_STAT: regRdData <= {customPkgPresent, shutActive_reg, linkNodeAddr,
                                         maxPowerAlloc, cfgSelect};
        default: regRdData <= 8'h00;
      endcase
    end
    else
      regRdData <= 8'h00;
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      deviceActive <= 1'b0;
    else
      deviceActive <= !chipRst_reg;
  end

  // open-drain pins only ever pull low; the enable decides
  assign intOut = 1'b0;
  assign serial_data_drive = 1'b0;

  property p_rst_ports_off;
    @(posedge clk) disable iff (!rst_n)
    chipRst_reg |=> (chanSwitchOn == 4'h0 && intOe_n && evt_reg == 8'h00);
  endproperty
  a_rst_ports_off: assert property (p_rst_ports_off) else $error("ports live in reset");

  property p_rst_release;
    @(posedge clk) disable iff (!rst_n)
    (chipRst_reg && sync2_reg.rstPin) |=> !chipRst_reg ##1 deviceActive;
  endproperty
  a_rst_release: assert property (p_rst_release) else $error("reset not left");

  property p_rst_filter;
    @(posedge clk) disable iff (!rst_n)
    $rose(chipRst_reg) |-> $past(rstLowCnt_reg) == 8'(RST_FILT) && !$past(sync2_reg.rstPin);
  endproperty
  a_rst_filter: assert property (p_rst_filter) else $error("reset glitch passed");

  property p_int_assert;
    @(posedge clk) disable iff (!rst_n)
    (!chipRst_reg && !busBusy_reg && !startSeen && |(evt_next & intMask_reg)) |=> !intOe_n;
  endproperty
  a_int_assert: assert property (p_int_assert) else $error("interrupt not driven");

  property p_int_release;
    @(posedge clk) disable iff (!rst_n)
    (wrEn && regAddr == `PSH_REG_RESET && regWrData[`PSH_RST_REL_HI] && evtSet == 8'h00)
      |=> evt_reg == 8'h00;
  endproperty
  a_int_release: assert property (p_int_release) else $error("events not released");

  property p_int_masked;
    @(posedge clk) disable iff (!rst_n)
    (!busBusy_reg && !startSeen && (evt_next & intMask_reg) == 8'h00) |=> intOe_n;
  endproperty
  a_int_masked: assert property (p_int_masked) else $error("masked event drove pin");

  property p_int_frozen;
    @(posedge clk) disable iff (!rst_n)
    (busBusy_reg && !chipRst_reg) |=> $stable(intOe_n);
  endproperty
  a_int_frozen: assert property (p_int_frozen) else $error("pin moved mid transaction");

  property p_ack_addr;
    @(posedge clk) disable iff (!rst_n)
    $fell(serialDataOe_n) |-> shift_reg[7:1] == {2'h1, strap_reg.addrBits, 1'b0};
  endproperty
  a_ack_addr: assert property (p_ack_addr) else $error("ack for foreign address");

  property p_fault_off;
    @(posedge clk) disable iff (!rst_n)
    (evtSet[0] && !chipRst_reg) |=> !chanSwitchOn[0] && evt_reg[0];
  endproperty
  a_fault_off: assert property (p_fault_off) else $error("faulted channel left on");

  property p_wake_quiet;
    @(posedge clk)
    $rose(rst_n) |-> intOe_n && evt_reg == 8'h00;
  endproperty
  a_wake_quiet: assert property (p_wake_quiet) else $error("interrupt after power-up");
endmodule
`default_nettype wire

// >>> src/psh_host_ctrl_params.svh
// constants for the host-facing control and strap block
`ifndef PSH_HOST_CTRL_PARAMS_SVH
`define PSH_HOST_CTRL_PARAMS_SVH
`define PSH_CLK_MHZ 100
`define PSH_RST_FILT_NS 1000
`define PSH_RST_FILT_CYC ((`PSH_RST_FILT_NS * `PSH_CLK_MHZ) / 1000)
`define PSH_SHDN_MIN_NS 3000
`define PSH_SHDN_FILT_CYC ((`PSH_SHDN_MIN_NS * `PSH_CLK_MHZ) / 2000)
`define PSH_REG_RESET 8'h00
`define PSH_REG_INT_MASK 8'h01
`define PSH_REG_EVENT 8'h02
`define PSH_REG_MODE 8'h03
`define PSH_REG_SHUT_MASK 8'h04
`define PSH_REG_PRIO_A 8'h05
`define PSH_REG_PRIO_B 8'h06
`define PSH_REG_POWER_REQ 8'h07
`define PSH_REG_CHAN_STAT 8'h08
`define PSH_REG_ADDR_STAT 8'h09
`define PSH_REG_CFG_STAT 8'h0A
`define PSH_RST_REL_LO 6
`define PSH_RST_REL_HI 7
`define PSH_MODE_AUTO 0
`define PSH_MODE_PRIO3 1
`define PSH_MODE_THR_LSB 2
`define PSH_INT_MASK_RST 8'hFF
`define PSH_MODE_RST 8'h00
`define PSH_ADDR_FIXED_HI 2'h1
`define PSH_ADDR_FIXED_LO 1'h0
`define PSH_STRAP_RST 10'h3C0
`define PSH_PWR_DEFAULT 2'h0
`endif

// >>> src/psh_pkg.sv
// types shared by the host-facing control block
package psh_pkg;
  typedef struct packed {
    logic [3:0] addrBits;
    logic [1:0] cfgSel;
    logic [1:0] linkNode;
    logic [1:0] powerMode;
  } psh_strap_t;
  typedef struct packed {
    logic rstPin;
    logic shutdown;
    logic scl;
    logic sda;
    logic linkClk;
    logic [3:0] faultTimer;
    logic [3:0] outBelow;
    logic [3:0] classOk;
    psh_strap_t strap;
  } psh_pins_t;
  typedef enum logic [3:0] {
    PSH_I2C_IDLE = 4'h1,
    PSH_I2C_ADDR = 4'h2,
    PSH_I2C_ACK = 4'h4,
    PSH_I2C_DATA = 4'h8
  } psh_i2c_state_t;
endpackage

// >>> tb/psh_i2c_host_model.sv
// host processor model that drives the split serial bus as a controller
`timescale 1ns/1ps
`default_nettype none
module psh_i2c_host_model #(
  parameter int PHASE_NS = 400
) (
  output logic scl,
  output logic sdaDrv,
  input wire logic sdaLine
);
  // both lines rest released high whenever no transfer is running
  initial
  begin
    scl = 1'b1;
    sdaDrv = 1'b1;
  end

  task automatic start_cond();
    sdaDrv = 1'b1;
    scl = 1'b1;
    #PHASE_NS sdaDrv = 1'b0;
    #PHASE_NS scl = 1'b0;
    #PHASE_NS;
  endtask

  task automatic send_byte(input logic [7:0] b, output logic ack);
    for (int i = 7; i >= 0; i--)
    begin
      sdaDrv = b[i];
      #PHASE_NS scl = 1'b1;
      #PHASE_NS scl = 1'b0;
      #PHASE_NS;
    end
    // let go of data so the addressed device can pull it low
    sdaDrv = 1'b1;
    #PHASE_NS scl = 1'b1;
    #(PHASE_NS / 2) ack = sdaLine;
    #(PHASE_NS / 2) scl = 1'b0;
    #PHASE_NS;
  endtask

  task automatic stop_cond();
    sdaDrv = 1'b0;
    #PHASE_NS scl = 1'b1;
    #PHASE_NS sdaDrv = 1'b1;
    #PHASE_NS;
  endtask
endmodule
`default_nettype wire

// >>> tb/tb_top.sv
// self-checking bench for the host control and strap block
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  logic clk, rst_n, resetPin_n, shutIn, linkClk, regWr, regRd, custPkg, custCfg0, ack;
  logic [3:0] fault, below, classOk, addrStrap;
  logic [1:0] cfgStrap, nodeStrap, pwrStrap, custPwr;
  logic [7:0] regAddr, regWrData;
  wire logic [7:0] regRdData;
  wire logic intOut, intOe_n, sdaDrive, sdaOe_n, deviceActive, scl, sdaHost, sdaLine;
  wire logic [3:0] switchOn;
  wire logic [1:0] maxPower, cfgSel, nodeAddr;
  int errors, testsRun, cycles;

  // open-drain data line with board pull-up
  assign sdaLine = sdaHost & (sdaOe_n | sdaDrive);

  psh_host_ctrl u_psh_host_ctrl (
    .clk(clk), .rst_n(rst_n), .resetPin_n(resetPin_n), .masked_shutdown_in(shutIn),
    .serialClk(scl), .serial_data_sense(sdaLine), .linkClk(linkClk),
    .chanFaultTimer(fault), .chanOutBelow(below), .chanClassOk(classOk),
    .addrStrap(addrStrap), .cfgStrap(cfgStrap), .link_node_strap(nodeStrap),
    .power_mode_strap(pwrStrap), .customPkgPresent(custPkg), .customCfg0(custCfg0),
    .customPowerMode(custPwr), .regAddr(regAddr), .regWrData(regWrData),
    .regWr(regWr), .regRd(regRd), .regRdData(regRdData), .intOut(intOut),
    .intOe_n(intOe_n), .serial_data_drive(sdaDrive), .serialDataOe_n(sdaOe_n),
    .chanSwitchOn(switchOn), .maxPowerAlloc(maxPower), .cfgSelect(cfgSel),
    .linkNodeAddr(nodeAddr), .deviceActive(deviceActive)
  );

  psh_i2c_host_model u_psh_i2c_host_model (
    .scl(scl), .sdaDrv(sdaHost), .sdaLine(sdaLine)
  );

  initial
  begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  // link clock has no phase relation to the core clock
  initial
  begin
    linkClk = 1'b0;
    #3;
    forever #62.5 linkClk = ~linkClk;
  end

  task automatic finish_test();
    $display("comparisons %0d mismatches %0d", testsRun, errors);
    if (errors == 0 && testsRun > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  always @(posedge clk)
  begin
    cycles++;
    if (cycles == 40000)
    begin
      errors++;
      finish_test();
    end
  end

  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
  endtask

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    testsRun++;
    if (got !== exp)
    begin
      errors++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    regAddr <= a;
    regWrData <= d;
    regWr <= 1'b1;
    @(posedge clk);
    regWr <= 1'b0;
    @(posedge clk);
  endtask

  // read data stand only in the cycle after the strobe
  task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
    regAddr <= a;
    regRd <= 1'b1;
    @(posedge clk);
    regRd <= 1'b0;
    #1 chk(regRdData, exp);
    @(posedge clk);
  endtask

  task automatic i2c_addr(input logic [7:0] b, input logic expAck, input logic doStop);
    u_psh_i2c_host_model.start_cond();
    u_psh_i2c_host_model.send_byte(b, ack);
    chk({7'h00, ack}, {7'h00, expAck});
    if (doStop)
      u_psh_i2c_host_model.stop_cond();
    @(posedge clk);
  endtask

  task automatic test_end(input string name);
    $display("test %s done", name);
  endtask

  initial
  begin
    errors = 0;
    testsRun = 0;
    cycles = 0;
    rst_n = 1'b0;
    resetPin_n = 1'b1;
    shutIn = 1'b0;
    regWr = 1'b0;
    regRd = 1'b0;
    regAddr = 8'h00;
    regWrData = 8'h00;
    fault = 4'h0;
    below = 4'h0;
    classOk = 4'h0;
    addrStrap = 4'hA;
    cfgStrap = 2'h2;
    nodeStrap = 2'h0;
    pwrStrap = 2'h2;
    custPkg = 1'b0;
    custCfg0 = 1'b0;
    custPwr = 2'h0;
    cyc(4);
    rst_n <= 1'b1;
    cyc(10);

    chk({7'h00, deviceActive}, 8'h01);
    chk({7'h00, intOe_n}, 8'h01);
    rd_chk(8'h01, 8'hFF);
    rd_chk(8'h02, 8'h00);
    rd_chk(8'h03, 8'h00);
    rd_chk(8'h20, 8'h00);
    rd_chk(8'h09, 8'h34);
    rd_chk(8'h0A, 8'h0A);
    chk({6'h00, cfgSel}, 8'h02);
    chk({6'h00, nodeAddr}, 8'h00);
    chk({6'h00, maxPower}, 8'h02);
    test_end("reset_and_straps");

    classOk <= 4'hF;
    wr(8'h03, 8'h01);
    cyc(30);
    chk({4'h0, switchOn}, 8'h0F);
    wr(8'h04, 8'h08);
    shutIn <= 1'b1;
    cyc(300);
    chk({4'h0, switchOn}, 8'h07);
    shutIn <= 1'b0;
    cyc(30);
    chk({4'h0, switchOn}, 8'h0F);
    wr(8'h05, 8'h29);
    wr(8'h03, 8'h0F);
    shutIn <= 1'b1;
    cyc(300);
    chk({4'h0, switchOn}, 8'h02);
    shutIn <= 1'b0;
    wr(8'h07, 8'h05);
    wr(8'h03, 8'h00);
    cyc(5);
    chk({4'h0, switchOn}, 8'h05);
    rd_chk(8'h08, 8'hF5);
    rd_chk(8'h05, 8'h29);
    wr(8'h03, 8'h01);
    cyc(30);
    test_end("auto_and_shutdown");

    fault <= 4'h1;
    cyc(30);
    chk({4'h0, switchOn}, 8'h0E);
    rd_chk(8'h02, 8'h01);
    chk({7'h00, intOe_n}, 8'h00);
    chk({7'h00, intOut}, 8'h00);
    chk({7'h00, sdaDrive}, 8'h00);
    wr(8'h01, 8'h00);
    cyc(3);
    chk({7'h00, intOe_n}, 8'h01);
    wr(8'h01, 8'hFF);
    cyc(3);
    chk({7'h00, intOe_n}, 8'h00);
    wr(8'h00, 8'h40);
    cyc(3);
    rd_chk(8'h02, 8'h00);
    chk({7'h00, intOe_n}, 8'h01);
    below <= 4'h2;
    cyc(30);
    rd_chk(8'h02, 8'h20);
    wr(8'h00, 8'h80);
    cyc(3);
    rd_chk(8'h02, 8'h00);
    chk({7'h00, intOe_n}, 8'h01);
    test_end("events_and_interrupt");

    i2c_addr(8'h68, 1'b0, 1'b0);
    fault <= 4'h5;
    cyc(40);
    chk({7'h00, intOe_n}, 8'h01);
    u_psh_i2c_host_model.stop_cond();
    @(posedge clk);
    cyc(20);
    chk({7'h00, intOe_n}, 8'h00);
    i2c_addr(8'hA0, 1'b1, 1'b1);
    test_end("serial_bus");

    wr(8'h01, 8'h0F);
    resetPin_n <= 1'b0;
    cyc(50);
    resetPin_n <= 1'b1;
    cyc(10);
    chk({7'h00, deviceActive}, 8'h01);
    rd_chk(8'h01, 8'h0F);
    fault <= 4'h0;
    below <= 4'h0;
    custPkg <= 1'b1;
    custCfg0 <= 1'b1;
    custPwr <= 2'h3;
    nodeStrap <= 2'h1;
    addrStrap <= 4'h5;
    resetPin_n <= 1'b0;
    cyc(400);
    chk({7'h00, deviceActive}, 8'h00);
    chk({4'h0, switchOn}, 8'h00);
    cyc(50);
    resetPin_n <= 1'b1;
    cyc(20);
    chk({7'h00, deviceActive}, 8'h01);
    chk({7'h00, intOe_n}, 8'h01);
    rd_chk(8'h01, 8'hFF);
    rd_chk(8'h02, 8'h00);
    chk({6'h00, cfgSel}, 8'h03);
    chk({6'h00, maxPower}, 8'h03);
    chk({6'h00, nodeAddr}, 8'h01);
    rd_chk(8'h09, 8'h2A);
    rd_chk(8'h0A, 8'h9F);
    test_end("reset_pin_and_custom");

    finish_test();
  end
endmodule
`default_nettype wire
